// ===== design/wfd_wake_frame_detector.sv
// wake frame detector: scans received bytes for wake frames and signals a wake event
//
// Behaviour
// - when enabled, scan every frame addressed to this node for the wake sequence.
// - wake sequence destination must be own station address or broadcast.
// - wake sequence is own 6-byte address sent 16 times back to back.
// - with password enabled, the 6-byte password must follow the repetitions directly.
// - six bytes of ff must directly precede the address repetitions.
// - sync stream and sequence may start at any byte of the frame.
// - a qualifying frame raises a pin pulse, a pin level or an interrupt flag.
// - frames with a bad crc never raise a wake event.
// - detection works on bytes, so every line speed is covered.
// - three wake types: plain sequence, sequence with password, custom pattern.
// - custom pattern compares the first 64 frame bytes under a byte mask.
// - software sets detection through the receive configuration register.
// - receive status register reports which wake condition occurred.
// - irq enable and wake irq flag live in the second interrupt status register.
`timescale 1ns/10ps
`default_nettype none
`include "wfd_cfg.svh"

module wfd_wake_frame_detector
  import wfd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // receive byte stream
  input wire logic rx_byte_vld_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_end_i,
  input wire logic rx_crc_ok_i,
  // identity and match values
  input wire logic [47:0] station_addr_i,
  input wire logic [47:0] password_i,
  input wire logic [511:0] pattern_i,
  input wire logic [63:0] pattern_mask_i,
  // register access
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // wake indications
  output logic wake_pin_o,
  output logic wake_irq_o
);

  // ----------------------------------------
  // byte views of the match values
  // ----------------------------------------
  logic [7:0] sa_b [6];
  logic [7:0] pw_b [6];
  logic [7:0] pat_b [64];

  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++) begin : g_bytes
      assign pat_b[gi] = pattern_i[511 - 8 * gi -: 8];
      if (gi < 6) begin : g_addr
        assign sa_b[gi] = station_addr_i[47 - 8 * gi -: 8];
        assign pw_b[gi] = password_i[47 - 8 * gi -: 8];
      end
    end
  endgenerate

  // ----------------------------------------
  // state
  // ----------------------------------------
  wfd_regs_t q;
  wfd_regs_t n;
  logic wake_ev;
  logic hit_magic;
  logic hit_pat;
  logic is_ff;

  assign is_ff = (rx_byte_i == `WFD_SYNC_BYTE);
  assign hit_magic = q.cfg[`WFD_CFG_EN] && (q.fsm == S_DONE) && (q.pos >= `WFD_HDR_LEN)
                     && (!q.own_miss || !q.bc_miss);
  assign hit_pat = q.cfg[`WFD_CFG_PAT_EN] && !q.pat_miss && (q.pos >= `WFD_PAT_LEN);
  assign wake_ev = rx_end_i && rx_crc_ok_i && (hit_magic || hit_pat);

  always_comb begin
    n = q;

    // ----------------------------------------
    // register access; clears come first so events win
    // ----------------------------------------
    if (reg_rd_i) begin
      case (reg_addr_i)
        `WFD_OFS_CFG: n.rdata = q.cfg;
        `WFD_OFS_STAT: begin
          n.rdata = {12'h000, q.stat};
          n.stat = 4'h0;
          if (q.cfg[`WFD_CFG_PIN_LVL]) begin
            n.pin = 1'b0;
          end
        end
        `WFD_OFS_IRQ2: begin
          n.rdata = 16'h0000;
          n.rdata[`WFD_IRQ_EN] = q.irq_en;
          n.rdata[`WFD_IRQ_FLAG] = q.irq_flag;
          n.irq_flag = 1'b0;
        end
        default: n.rdata = 16'h0000;
      endcase
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        `WFD_OFS_CFG: n.cfg = reg_wdata_i & `WFD_CFG_MASK;
        `WFD_OFS_IRQ2: n.irq_en = reg_wdata_i[`WFD_IRQ_EN];
        default: ;
      endcase
    end

    // ----------------------------------------
    // per-byte scan, independent of line speed
    // ----------------------------------------
    if (rx_byte_vld_i && !rx_end_i) begin
      if (q.pos != `WFD_POS_MAX) begin
        n.pos = q.pos + 7'h01;
      end
      if (q.pos < `WFD_HDR_LEN) begin
        if (rx_byte_i != sa_b[q.pos[2:0]]) begin
          n.own_miss = 1'b1;
        end
        if (!is_ff) begin
          n.bc_miss = 1'b1;
        end
      end
      if ((q.pos < `WFD_PAT_LEN) && pattern_mask_i[q.pos[5:0]]
          && (rx_byte_i != pat_b[q.pos[5:0]])) begin
        n.pat_miss = 1'b1;
      end
      if (q.cfg[`WFD_CFG_EN]) begin
        case (q.fsm)
          S_SYNC: begin
            if (is_ff) begin
              if (q.scnt != `WFD_SYNC_LEN) begin
                n.scnt = q.scnt + 3'h1;
              end
            end else if ((q.scnt == `WFD_SYNC_LEN) && (rx_byte_i == sa_b[0])) begin
              n.fsm = S_ADDR;
              n.bidx = 3'h1;
              n.rep = 4'h0;
            end else begin
              n.scnt = 3'h0;
            end
          end
          S_ADDR: begin
            if (rx_byte_i == sa_b[q.bidx]) begin
              if (q.bidx == `WFD_LAST_BYTE) begin
                n.bidx = 3'h0;
                if (q.rep == `WFD_LAST_REP) begin
                  n.fsm = q.cfg[`WFD_CFG_PW_EN] ? S_PASS : S_DONE;
                end else begin
                  n.rep = q.rep + 4'h1;
                end
              end else begin
                n.bidx = q.bidx + 3'h1;
              end
            end else begin
              n.fsm = S_SYNC;
              n.scnt = is_ff ? 3'h1 : 3'h0;
            end
          end
          S_PASS: begin
            if (rx_byte_i == pw_b[q.bidx]) begin
              if (q.bidx == `WFD_LAST_BYTE) begin
                n.fsm = S_DONE;
              end else begin
                n.bidx = q.bidx + 3'h1;
              end
            end else begin
              n.fsm = S_SYNC;
              n.scnt = is_ff ? 3'h1 : 3'h0;
            end
          end
          S_DONE: ;
          default: n.fsm = S_SYNC;
        endcase
      end
    end

    // ----------------------------------------
    // frame end decision
    // ----------------------------------------
    if (rx_end_i) begin
      if (rx_crc_ok_i) begin
        if (hit_magic) begin
          if (q.cfg[`WFD_CFG_PW_EN]) begin
            n.stat[`WFD_ST_MAGIC_PW] = 1'b1;
          end else begin
            n.stat[`WFD_ST_MAGIC] = 1'b1;
          end
        end
        if (hit_pat) begin
          n.stat[`WFD_ST_PAT] = 1'b1;
        end
      end else if (hit_magic || hit_pat) begin
        n.stat[`WFD_ST_CRC_BAD] = 1'b1;
      end
      n.fsm = S_SYNC;
      n.scnt = 3'h0;
      n.bidx = 3'h0;
      n.rep = 4'h0;
      n.pos = 7'h00;
      n.own_miss = 1'b0;
      n.bc_miss = 1'b0;
      n.pat_miss = 1'b0;
    end

    // ----------------------------------------
    // wake indications
    // ----------------------------------------
    if (q.pcnt != 4'h0) begin
      n.pcnt = q.pcnt - 4'h1;
    end
    if (wake_ev) begin
      n.irq_flag = 1'b1;
      if (q.cfg[`WFD_CFG_PIN_EN]) begin
        if (q.cfg[`WFD_CFG_PIN_LVL]) begin
          n.pin = 1'b1;
        end else begin
          n.pcnt = `WFD_PULSE_CYC;
        end
      end
    end
    if (!q.cfg[`WFD_CFG_PIN_LVL]) begin
      n.pin = (n.pcnt != 4'h0);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      q <= '0;
      q.cfg <= `WFD_CFG_RST;
      q.irq_en <= `WFD_IRQ_RST;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign wake_pin_o = q.pin;
  assign wake_irq_o = q.irq_flag && q.irq_en;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence s_pulse_high;
    wake_pin_o [*8];
  endsequence

  sequence s_pulse_end;
    !wake_pin_o && (q.pcnt == 4'h0);
  endsequence

  property p_crc_gate;
    rx_end_i && !rx_crc_ok_i && !q.irq_flag |=> !q.irq_flag;
  endproperty
  a_crc_gate: assert property (p_crc_gate) else $error("bad crc frame set wake flag");

  property p_sync_first;
    (q.fsm == S_ADDR) && ($past(q.fsm) == S_SYNC) |-> ($past(q.scnt) == `WFD_SYNC_LEN);
  endproperty
  a_sync_first: assert property (p_sync_first) else $error("address run without sync stream");

  property p_sixteen;
    (q.fsm inside {S_PASS, S_DONE}) && ($past(q.fsm) == S_ADDR) |-> ($past(q.rep) == 4'hf);
  endproperty
  a_sixteen: assert property (p_sixteen) else $error("sequence ended before sixteen copies");

  property p_password;
    (q.fsm == S_DONE) && ($past(q.fsm) == S_ADDR) |-> !$past(q.cfg[`WFD_CFG_PW_EN]);
  endproperty
  a_password: assert property (p_password) else $error("password step skipped");

  property p_restart;
    rx_byte_vld_i && !rx_end_i && (q.fsm == S_ADDR) && (rx_byte_i != sa_b[q.bidx])
      |=> (q.fsm == S_SYNC);
  endproperty
  a_restart: assert property (p_restart) else $error("mismatch did not restart search");

  property p_end_only;
    $rose(q.stat[`WFD_ST_MAGIC]) || $rose(q.stat[`WFD_ST_PAT]) |-> $past(rx_end_i && rx_crc_ok_i);
  endproperty
  a_end_only: assert property (p_end_only) else $error("wake status set outside frame end");

  property p_pulse;
    wake_ev && q.cfg[`WFD_CFG_PIN_EN] && !q.cfg[`WFD_CFG_PIN_LVL] && !reg_wr_i
      |=> s_pulse_high ##1 s_pulse_end;
  endproperty
  a_pulse: assert property (p_pulse) else $error("wake pulse width wrong");

  property p_enabled;
    $rose(q.stat[`WFD_ST_MAGIC]) |-> $past(q.cfg[`WFD_CFG_EN]) && $past(q.fsm == S_DONE);
  endproperty
  a_enabled: assert property (p_enabled) else $error("wake sequence seen while disabled");

  property p_dest;
    $rose(q.stat[`WFD_ST_MAGIC_PW]) |-> $past(!q.own_miss || !q.bc_miss);
  endproperty
  a_dest: assert property (p_dest) else $error("wake frame not addressed to node");

  property p_pat_len;
    $rose(q.stat[`WFD_ST_PAT]) |-> ($past(q.pos) >= `WFD_PAT_LEN) && !$past(q.pat_miss);
  endproperty
  a_pat_len: assert property (p_pat_len) else $error("pattern hit on short or wrong frame");

  property p_irq_out;
    wake_ev && q.irq_en && !reg_wr_i |=> wake_irq_o [*2];
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("wake irq not raised");

endmodule
`default_nettype wire

// ===== design/wfd_cfg.svh
// wake frame detector register offsets, field positions, reset values and counts
`ifndef WFD_CFG_SVH
`define WFD_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define WFD_OFS_IRQ2 16'h0013
`define WFD_OFS_CFG 16'h04a0
`define WFD_OFS_STAT 16'h04a1

// ----------------------------------------
// wake_receive_config fields
// ----------------------------------------
`define WFD_CFG_EN 0
`define WFD_CFG_PW_EN 1
`define WFD_CFG_PAT_EN 2
`define WFD_CFG_PIN_EN 4
`define WFD_CFG_PIN_LVL 5
`define WFD_CFG_MASK 16'h0037
`define WFD_CFG_RST 16'h0000

// ----------------------------------------
// wake_receive_status fields
// ----------------------------------------
`define WFD_ST_MAGIC 0
`define WFD_ST_MAGIC_PW 1
`define WFD_ST_PAT 2
`define WFD_ST_CRC_BAD 3

// ----------------------------------------
// wake_irq_status_two fields
// ----------------------------------------
`define WFD_IRQ_EN 0
`define WFD_IRQ_FLAG 8
`define WFD_IRQ_RST 1'b0

// ----------------------------------------
// sequence counts and timing
// ----------------------------------------
`define WFD_SYNC_LEN 3'h6
`define WFD_LAST_BYTE 3'h5
`define WFD_LAST_REP 4'hf
`define WFD_HDR_LEN 7'h06
`define WFD_PAT_LEN 7'h40
`define WFD_POS_MAX 7'h7f
`define WFD_SYNC_BYTE 8'hff
`define WFD_PULSE_NS 320
`define WFD_CLK_NS 40
`define WFD_PULSE_CYC 4'((`WFD_PULSE_NS + `WFD_CLK_NS - 1) / `WFD_CLK_NS)

`endif

// ===== design/wfd_pkg.sv
// wake frame detector types
package wfd_pkg;

  typedef enum logic [1:0] {
    S_SYNC,
    S_ADDR,
    S_PASS,
    S_DONE
  } wfd_state_t;

  typedef struct packed {
    logic [15:0] cfg;
    logic [3:0] stat;
    logic irq_en;
    logic irq_flag;
    wfd_state_t fsm;
    logic [2:0] scnt;
    logic [2:0] bidx;
    logic [3:0] rep;
    logic [6:0] pos;
    logic own_miss;
    logic bc_miss;
    logic pat_miss;
    logic pin;
    logic [3:0] pcnt;
    logic [15:0] rdata;
  } wfd_regs_t;

endpackage

// ===== sim/wfd_host_model.sv
// host model that counts wake pin events and notes the irq line
`timescale 1ns/10ps
`default_nettype none
module wfd_host_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // wake indications
  input wire logic wake_pin_i,
  input wire logic wake_irq_i,
  // what the host saw
  output logic [7:0] wake_count_o,
  output logic irq_seen_o
);
  logic pin_d;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pin_d <= 1'b0;
      wake_count_o <= 8'h00;
      irq_seen_o <= 1'b0;
    end else begin
      pin_d <= wake_pin_i;
      // one wake per rising pin edge
      if (wake_pin_i && !pin_d) begin
        wake_count_o <= wake_count_o + 8'h01;
      end
      if (wake_irq_i) begin
        irq_seen_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the wake frame detector
`timescale 1ns/10ps
`default_nettype none
`include "wfd_cfg.svh"
module tb;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic vld = 1'b0;
  logic rend = 1'b0;
  logic crcok = 1'b0;
  logic rr = 1'b0;
  logic rw = 1'b0;
  logic [7:0] byt = 8'h00;
  logic [47:0] sa = 48'h0;
  logic [47:0] pw = 48'h0;
  logic [511:0] pat = 512'h0;
  logic [63:0] pmask = 64'h0;
  logic [15:0] ra = 16'h0;
  logic [15:0] wd = 16'h0;
  logic [15:0] rdata;
  logic pin;
  logic irq;
  logic [7:0] hcnt;
  logic hirq;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int nexp = 0;
  logic [7:0] q[$];

  always #20 clk_sys_i = ~clk_sys_i;

  wfd_wake_frame_detector u_wfd_wake_frame_detector (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .rx_byte_vld_i(vld), .rx_byte_i(byt), .rx_end_i(rend),
    .rx_crc_ok_i(crcok), .station_addr_i(sa), .password_i(pw), .pattern_i(pat), .pattern_mask_i(pmask),
    .reg_addr_i(ra), .reg_wr_i(rw), .reg_rd_i(rr), .reg_wdata_i(wd), .reg_rdata_o(rdata),
    .wake_pin_o(pin), .wake_irq_o(irq));

  wfd_host_model u_wfd_host_model (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .wake_pin_i(pin),
    .wake_irq_i(irq), .wake_count_o(hcnt), .irq_seen_o(hirq));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    rw <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk_sys_i);
    rw <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    rr <= 1'b1;
    ra <= a;
    @(posedge clk_sys_i);
    rr <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic push48(input logic [47:0] v);
    for (int k = 0; k < 6; k++) q.push_back(v[47-8*k -: 8]);
  endtask

  // dst 0 own 1 broadcast 2 foreign; brk 1 broken only, 2 broken then full, 3 pattern frame
  task automatic run_case(input int dst, input int nff, input int brk, input int pws, input int crc,
                          input int lvl, input logic pwc, input logic [15:0] exp);
    logic [15:0] d;
    logic [47:0] dest;
    int n;
    logic evt;
    logic seen;
    evt = (exp[2:0] != 3'h0);
    nexp += int'(evt);
    n = 0;
    seen = 1'b0;
    wr(`WFD_OFS_CFG, brk == 3 ? 16'h0014 : {10'h0, lvl[0], 1'b1, 2'h0, pwc, 1'b1});
    dest = dst == 0 ? sa : (dst == 1 ? 48'hffffffffffff : sa ^ 48'h1);
    q.delete();
    if (brk == 3) begin
      for (int k = 0; k < 64; k++) q.push_back(pmask[k] ? pat[511-8*k -: 8] : 8'($urandom));
    end else begin
      push48(dest);
      push48(48'({$urandom, $urandom}) & 48'h7f7f7f7f7f7f);
      if (brk != 0) begin
        push48(48'hffffffffffff);
        repeat (8) push48(sa);
        q.push_back(8'h00);
      end
      if (brk != 1) begin
        repeat (nff) q.push_back(8'hff);
        repeat (16) push48(sa);
        if (pws != 0) push48(pw);
      end
      q.push_back(8'h00);
    end
    foreach (q[i]) begin
      @(posedge clk_sys_i);
      vld <= 1'b1;
      byt <= q[i];
    end
    @(posedge clk_sys_i);
    vld <= 1'b0;
    rend <= 1'b1;
    crcok <= crc[0];
    @(posedge clk_sys_i);
    rend <= 1'b0;
    repeat (16) begin
      #1;
      n += int'(pin === 1'b1);
      seen |= (irq === 1'b1);
      @(posedge clk_sys_i);
    end
    #1;
    if (lvl == 0) chk(16'(n), evt ? 16'h0008 : 16'h0000);
    chk({15'h0, pin}, {15'h0, evt & lvl[0]});
    chk({15'h0, seen}, {15'h0, evt});
    rd(`WFD_OFS_STAT, d);
    chk(d, exp);
    rd(`WFD_OFS_STAT, d);
    chk(d, 16'h0000);
    rd(`WFD_OFS_IRQ2, d);
    chk(d, {7'h0, evt, 8'h01});
    chk({14'h0, pin, irq}, 16'h0000);
    $display("frame test done status %h", exp);
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] d;
    void'($urandom(32'h3f23c938));
    sa = 48'({$urandom, $urandom}) & 48'h7f7f7f7f7f7f;
    pw = 48'({$urandom, $urandom}) & 48'h7f7f7f7f7f7f;
    pmask = {$urandom, $urandom} | 64'h3f;
    for (int k = 0; k < 64; k++) pat[511-8*k -: 8] = 8'($urandom);
    pat[511 -: 48] = sa;
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rd(`WFD_OFS_CFG, d);
    chk(d, 16'h0000);
    rd(`WFD_OFS_STAT, d);
    chk(d, 16'h0000);
    rd(`WFD_OFS_IRQ2, d);
    chk(d, 16'h0000);
    rd(16'h0100, d);
    chk(d, 16'h0000);
    wr(`WFD_OFS_CFG, 16'hffff);
    rd(`WFD_OFS_CFG, d);
    chk(d, 16'h0037);
    wr(`WFD_OFS_STAT, 16'hffff);
    rd(`WFD_OFS_STAT, d);
    chk(d, 16'h0000);
    wr(`WFD_OFS_IRQ2, 16'h0001);
    $display("register test done");
    run_case(0, 6, 0, 0, 1, 0, 1'b0, 16'h0001);
    run_case(1, 6, 0, 0, 1, 0, 1'b0, 16'h0001);
    run_case(2, 6, 0, 0, 1, 0, 1'b0, 16'h0000);
    run_case(0, 6, 0, 0, 0, 0, 1'b0, 16'h0008);
    run_case(0, 6, 1, 0, 1, 0, 1'b0, 16'h0000);
    run_case(0, 6, 2, 0, 1, 0, 1'b0, 16'h0001);
    run_case(0, 5, 0, 0, 1, 0, 1'b0, 16'h0000);
    run_case(0, 8, 0, 1, 1, 1, 1'b1, 16'h0002);
    run_case(0, 6, 0, 0, 1, 0, 1'b1, 16'h0000);
    run_case(0, 6, 3, 0, 1, 0, 1'b0, 16'h0004);
    repeat (4) run_case(int'($urandom % 2), 6 + int'($urandom % 3), 0, 0, 1, 0, 1'b0, 16'h0001);
    chk({8'h0, hcnt}, 16'(nexp));
    chk({15'h0, hirq}, 16'h0001);
    give_verdict();
  end
endmodule
`default_nettype wire
